// ### mpm_map.svh
`ifndef MPM_MAP_SVH
`define MPM_MAP_SVH
// ****************************************
// register offsets (byte addresses)
// ****************************************
`define MPM_OFS_ISEL 8'h00
`define MPM_OFS_VALID 8'h04
`define MPM_OFS_S1_SEL 8'h08
`define MPM_OFS_S1_LNK 8'h0c
`define MPM_OFS_S1_CTL 8'h10
`define MPM_OFS_S2_SEL 8'h18
`define MPM_OFS_S2_LNK 8'h20
`define MPM_OFS_S2_CTL 8'h27
`define MPM_OFS_S3_SEL 8'h28
`define MPM_OFS_S3_LNK 8'h30
`define MPM_OFS_S3_CTL 8'h37
`define MPM_OFS_OSEL 8'h38
`define MPM_OFS_DEST 8'h3f
`define MPM_OFS_MONITOR 8'h40
`define MPM_OFS_IRQ_STS 8'h41
`define MPM_OFS_IRQ_MSK 8'h42
// ****************************************
// selector and link codes
// ****************************************
`define MPM_CODE_NONE 8'h00
`define MPM_CODE_PIN 8'h01
`define MPM_CODE_TIMER 8'h16
`define MPM_CODE_POS0 8'h07
`define MPM_CODE_NEG0 8'h17
`define MPM_CODE_S1_OUT0 8'h0d
`define MPM_CODE_S1_OUT1 8'h0e
`define MPM_CODE_ISEL8U 8'h03
`define MPM_CODE_ISEL9U 8'h04
`define MPM_LNK_IN0 8'h01
`define MPM_LNK_IN1 8'h02
`define MPM_LNK_CLK 8'h03
`define MPM_LNK_SET0 8'h0a
`define MPM_OSEL_S2_OUT0 8'h06
`define MPM_OSEL_S2_OUT3 8'h09
`define MPM_OSEL_S2_OUT4 8'h0a
`define MPM_OSEL_S3_OUT3 8'h0e
`define MPM_OSEL_S3_OUT4 8'h0f
// ****************************************
// control field positions and cell modes
// ****************************************
`define MPM_CTL_FF0_EN 6
`define MPM_CTL_FF1_EN 7
`define MPM_MODE_AND 2'b01
`define MPM_MODE_OR 2'b10
`define MPM_MODE_XOR 2'b11
// ****************************************
// reset values
// ****************************************
`define MPM_RST_BYTE 8'h00
`define MPM_RST_VALID 4'h0
`endif

// ### mpm_pkg.sv
package mpm_pkg;
  // trigger destinations of the combined output
  typedef enum logic [2:0] {
    MPM_DEST_INTR = 3'h0,
    MPM_DEST_XFER = 3'h1,
    MPM_DEST_SEQ = 3'h2,
    MPM_DEST_ADC = 3'h3,
    MPM_DEST_DAC0 = 3'h4,
    MPM_DEST_DAC1 = 3'h5,
    MPM_DEST_TOUCH = 3'h6,
    MPM_DEST_CAPTURE = 3'h7
  } mpm_dest_t;

  // routing result of one link-select bank
  typedef struct packed {
    logic in0;
    logic in1;
    logic set0;
    logic set1;
    logic ff_clk;
  } mpm_route_t;

  // module state apart from the reset release flip-flops
  typedef struct packed {
    logic [3:0][7:0] isel;
    logic [3:0] valid;
    logic [3:0][7:0] s1_sel;
    logic [3:0][7:0] s1_lnk;
    logic [7:0] s1_ctl;
    logic [6:0][7:0] s2_sel;
    logic [6:0][7:0] s2_lnk;
    logic [7:0] s2_ctl;
    logic [6:0][7:0] s3_sel;
    logic [6:0][7:0] s3_lnk;
    logic [7:0] s3_ctl;
    logic [6:0][7:0] osel;
    mpm_dest_t dest;
    logic [1:0] s2_ff;
    logic [1:0] s3_ff;
    logic s2_clk_q;
    logic s3_clk_q;
    logic comb_q;
    logic [1:0] irq_sts;
    logic [1:0] irq_msk;
    logic irq;
    logic [7:0] trig;
    logic [7:0] rdata;
  } mpm_state_t;
endpackage : mpm_pkg

// ### mpm_event_monitor.sv
`include "mpm_map.svh"
module mpm_event_monitor
  import mpm_pkg::*;
#(
  parameter int N_IN = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N_IN-1:0] timer_event,
  input wire logic [N_IN-1:0] port_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  output logic [7:0] rdata,
  output logic [7:0] trig,
  output logic irq
);

  // ****************************************
  // reset release
  // ****************************************
  logic rst_meta_b; // first stage, read only by second
  logic rst_sync_b; // released copy used everywhere

  // async assert, release after two edges
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      rst_meta_b <= 1'b0;
      rst_sync_b <= 1'b0;
    end else begin
      rst_meta_b <= 1'b1;
      rst_sync_b <= rst_meta_b;
    end
  end

  // ****************************************
  // helper functions
  // ****************************************
  // one logic cell; disabled mode yields low
  function automatic logic cell_op(input logic [1:0] mode, input logic a, input logic b);
    case (mode)
      `MPM_MODE_OR: cell_op = a | b;
      `MPM_MODE_AND: cell_op = a & b;
      `MPM_MODE_XOR: cell_op = a ^ b;
      default: cell_op = 1'b0;
    endcase
  endfunction : cell_op

  // stage1 pick: positive or inverted copy of selectors 6-9
  function automatic logic s1_pick(input logic [7:0] code, input logic [3:0] src);
    s1_pick = 1'b0;
    for (int k = 0; k < 4; k++) begin
      if (code == `MPM_CODE_POS0 + 8'(k)) begin
        s1_pick = src[k];
      end
      if (code == `MPM_CODE_NEG0 + 8'(k)) begin
        s1_pick = ~src[k];
      end
    end
  endfunction : s1_pick

  // stage2/3 pick: selectors, inverted selectors or stage1 outputs, else constant low
  function automatic logic s23_pick(input logic [7:0] code, input logic [3:0] src, input logic [1:0] s1o);
    case (code)
      `MPM_CODE_ISEL8U: s23_pick = src[2];
      `MPM_CODE_ISEL9U: s23_pick = src[3];
      `MPM_CODE_S1_OUT0: s23_pick = s1o[0];
      `MPM_CODE_S1_OUT1: s23_pick = s1o[1];
      default: begin
        // codes 07H..0AH reuse the stage1 positive mapping
        s23_pick = s1_pick(code, src);
      end
    endcase
  endfunction : s23_pick

  // decode one bank of link selectors into cell and flip-flop inputs
  function automatic mpm_route_t route(input logic [6:0] sig, input logic [6:0][7:0] lnk);
    mpm_route_t r;
    r = '0;
    for (int k = 0; k < 7; k++) begin
      case (lnk[k])
        `MPM_LNK_SET0: r.set0 = r.set0 | sig[k];
        `MPM_LNK_IN0: begin
          // low links feed the cell, upper links set flip-flop 1
          if (k < 4) begin
            r.in0 = r.in0 | sig[k];
          end else begin
            r.set1 = r.set1 | sig[k];
          end
        end
        `MPM_LNK_IN1: r.in1 = r.in1 | sig[k];
        `MPM_LNK_CLK: r.ff_clk = r.ff_clk | sig[k];
        default: r = r;
      endcase
    end
    route = r;
  endfunction : route

  // ****************************************
  // state
  // ****************************************
  mpm_state_t st_r; // registered state
  mpm_state_t st_nxt; // next state

  // ****************************************
  // fabric and register next-state logic
  // ****************************************
  always_comb begin
    logic [3:0] src; // clamped selector outputs
    logic [3:0] s1_sig; // stage1 signal selector outputs
    logic [1:0] s1_in0; // stage1 cell input 0
    logic [1:0] s1_in1; // stage1 cell input 1
    logic [1:0] s1_out; // stage1 cell outputs
    logic [6:0] s2_sig; // stage2 signal selector outputs
    logic [6:0] s3_sig; // stage3 signal selector outputs
    mpm_route_t r2; // stage2 routing
    mpm_route_t r3; // stage3 routing
    logic [4:0] s2_out; // stage2 output vector
    logic [4:0] s3_out; // stage3 output vector
    logic [6:0] osel_out; // output selector results
    logic comb; // combined monitored level
    logic rise; // rising edge of combined level
    logic [1:0] evt; // status events
    logic [3:0] mon; // monitor view of flip-flops
    logic [3:0] mon_clr; // software clear of monitor bits
    logic [7:0] rd_val; // read mux
    src = '0;
    s1_sig = '0;
    s1_in0 = '0;
    s1_in1 = '0;
    s1_out = '0;
    s2_sig = '0;
    s3_sig = '0;
    osel_out = '0;
    r2 = '0;
    r3 = '0;
    s2_out = '0;
    s3_out = '0;
    comb = 1'b0;
    rise = 1'b0;
    evt = '0;
    mon = '0;
    mon_clr = '0;
    rd_val = 8'h00;
    st_nxt = st_r;

    // input selectors 6..9 with validity clamp
    for (int k = 0; k < 4; k++) begin
      if (st_r.isel[k] == `MPM_CODE_TIMER) begin
        src[k] = timer_event[k];
      end else if (st_r.isel[k] == `MPM_CODE_PIN) begin
        src[k] = port_pin[k];
      end
      src[k] = src[k] & st_r.valid[k];
    end

    // stage1: four selectors, four links, two cells
    for (int k = 0; k < 4; k++) begin
      s1_sig[k] = s1_pick(st_r.s1_sel[k], src);
      for (int c = 0; c < 2; c++) begin
        if (st_r.s1_lnk[k] == 8'(2 * c + 1)) begin
          s1_in0[c] = s1_in0[c] | s1_sig[k];
        end
        if (st_r.s1_lnk[k] == 8'(2 * c + 2)) begin
          s1_in1[c] = s1_in1[c] | s1_sig[k];
        end
      end
    end
    for (int c = 0; c < 2; c++) begin
      s1_out[c] = cell_op(st_r.s1_ctl[2*c+:2], s1_in0[c], s1_in1[c]);
    end

    // stages 2 and 3: seven selectors each
    for (int k = 0; k < 7; k++) begin
      s2_sig[k] = s23_pick(st_r.s2_sel[k], src, s1_out);
      s3_sig[k] = s23_pick(st_r.s3_sel[k], src, s1_out);
    end
    r2 = route(s2_sig, st_r.s2_lnk);
    r3 = route(s3_sig, st_r.s3_lnk);

    // flip-flops: set wins over clock and software clear
    mon = {st_r.s3_ff[1], st_r.s2_ff[1], st_r.s3_ff[0], st_r.s2_ff[0]};
    if (wr && addr == `MPM_OFS_MONITOR) begin
      mon_clr = wdata[3:0];
    end
    // a rising ff clock loads the constant-low data input
    for (int f = 0; f < 2; f++) begin
      st_nxt.s2_ff[f] = (st_r.s2_ctl[`MPM_CTL_FF0_EN + f] & (f == 0 ? r2.set0 : r2.set1))
        | (st_r.s2_ff[f] & ~mon_clr[2*f] & ~(r2.ff_clk & ~st_r.s2_clk_q));
      st_nxt.s3_ff[f] = (st_r.s3_ctl[`MPM_CTL_FF0_EN + f] & (f == 0 ? r3.set0 : r3.set1))
        | (st_r.s3_ff[f] & ~mon_clr[2*f+1] & ~(r3.ff_clk & ~st_r.s3_clk_q));
    end
    st_nxt.s2_clk_q = r2.ff_clk;
    st_nxt.s3_clk_q = r3.ff_clk;

    // fabric output vectors: cell at 0, flip-flops at 3 and 4
    s2_out = {st_r.s2_ff[1], st_r.s2_ff[0], 2'b00, cell_op(st_r.s2_ctl[1:0], r2.in0, r2.in1)};
    s3_out = {st_r.s3_ff[1], st_r.s3_ff[0], 2'b00, cell_op(st_r.s3_ctl[1:0], r3.in0, r3.in1)};

    // output selectors
    for (int k = 0; k < 7; k++) begin
      case (st_r.osel[k])
        `MPM_OSEL_S2_OUT0: osel_out[k] = s2_out[0];
        `MPM_OSEL_S2_OUT3: osel_out[k] = s2_out[3];
        `MPM_OSEL_S2_OUT4: osel_out[k] = s2_out[4];
        `MPM_OSEL_S3_OUT3: osel_out[k] = s3_out[3];
        `MPM_OSEL_S3_OUT4: osel_out[k] = s3_out[4];
        default: osel_out[k] = 1'b0;
      endcase
    end

    // combined output: only a low-to-high change fires
    comb = osel_out[0];
    rise = comb & ~st_r.comb_q;
    st_nxt.comb_q = comb;
    st_nxt.trig = '0;
    st_nxt.trig[st_r.dest] = rise;

    // status events: bit0 event-link interrupt, bit1 a flip-flop newly set
    evt[0] = rise & (st_r.dest == MPM_DEST_INTR);
    evt[1] = |({st_nxt.s3_ff, st_nxt.s2_ff} & ~{st_r.s3_ff, st_r.s2_ff});
    st_nxt.irq_sts = st_r.irq_sts;
    if (wr && addr == `MPM_OFS_IRQ_STS) begin
      st_nxt.irq_sts = st_r.irq_sts & ~wdata[1:0];
    end
    // set beats a same-cycle clear
    st_nxt.irq_sts = st_nxt.irq_sts | evt;

    // register writes
    if (wr) begin
      for (int k = 0; k < 4; k++) begin
        if (addr == `MPM_OFS_ISEL + 8'(k)) st_nxt.isel[k] = wdata;
        if (addr == `MPM_OFS_S1_SEL + 8'(k)) st_nxt.s1_sel[k] = wdata;
        if (addr == `MPM_OFS_S1_LNK + 8'(k)) st_nxt.s1_lnk[k] = wdata;
      end
      for (int k = 0; k < 7; k++) begin
        if (addr == `MPM_OFS_S2_SEL + 8'(k)) st_nxt.s2_sel[k] = wdata;
        if (addr == `MPM_OFS_S2_LNK + 8'(k)) st_nxt.s2_lnk[k] = wdata;
        if (addr == `MPM_OFS_S3_SEL + 8'(k)) st_nxt.s3_sel[k] = wdata;
        if (addr == `MPM_OFS_S3_LNK + 8'(k)) st_nxt.s3_lnk[k] = wdata;
        if (addr == `MPM_OFS_OSEL + 8'(k)) st_nxt.osel[k] = wdata;
      end
      case (addr)
        `MPM_OFS_VALID: st_nxt.valid = wdata[3:0];
        `MPM_OFS_S1_CTL: st_nxt.s1_ctl = wdata;
        `MPM_OFS_S2_CTL: st_nxt.s2_ctl = wdata;
        `MPM_OFS_S3_CTL: st_nxt.s3_ctl = wdata;
        `MPM_OFS_DEST: st_nxt.dest = mpm_dest_t'(wdata[2:0]);
        `MPM_OFS_IRQ_MSK: st_nxt.irq_msk = wdata[1:0];
        default: st_nxt.dest = st_nxt.dest;
      endcase
    end
    // level interrupt uses the new mask, so a mask write acts at once
    st_nxt.irq = |(st_nxt.irq_sts & st_nxt.irq_msk);

    // register reads, answered one cycle later
    if (rd) begin
      for (int k = 0; k < 4; k++) begin
        if (addr == `MPM_OFS_ISEL + 8'(k)) rd_val = st_r.isel[k];
        if (addr == `MPM_OFS_S1_SEL + 8'(k)) rd_val = st_r.s1_sel[k];
        if (addr == `MPM_OFS_S1_LNK + 8'(k)) rd_val = st_r.s1_lnk[k];
      end
      for (int k = 0; k < 7; k++) begin
        if (addr == `MPM_OFS_S2_SEL + 8'(k)) rd_val = st_r.s2_sel[k];
        if (addr == `MPM_OFS_S2_LNK + 8'(k)) rd_val = st_r.s2_lnk[k];
        if (addr == `MPM_OFS_S3_SEL + 8'(k)) rd_val = st_r.s3_sel[k];
        if (addr == `MPM_OFS_S3_LNK + 8'(k)) rd_val = st_r.s3_lnk[k];
        if (addr == `MPM_OFS_OSEL + 8'(k)) rd_val = st_r.osel[k];
      end
      case (addr)
        `MPM_OFS_VALID: rd_val = {4'h0, st_r.valid};
        `MPM_OFS_S1_CTL: rd_val = st_r.s1_ctl;
        `MPM_OFS_S2_CTL: rd_val = st_r.s2_ctl;
        `MPM_OFS_S3_CTL: rd_val = st_r.s3_ctl;
        `MPM_OFS_DEST: rd_val = {5'h00, st_r.dest};
        `MPM_OFS_MONITOR: rd_val = {4'h0, mon};
        `MPM_OFS_IRQ_STS: rd_val = {6'h00, st_r.irq_sts};
        `MPM_OFS_IRQ_MSK: rd_val = {6'h00, st_r.irq_msk};
        default: rd_val = rd_val; // unmapped reads as zero
      endcase
    end
    st_nxt.rdata = rd_val;
  end

  // ****************************************
  // state register
  // ****************************************
  // all selectors reset to no-selection, inputs invalid
  always_ff @(posedge clk or negedge rst_sync_b) begin
    if (!rst_sync_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  // outputs come straight from flip-flops
  assign rdata = st_r.rdata;
  assign trig = st_r.trig;
  assign irq = st_r.irq;

endmodule : mpm_event_monitor

// ### mpm_event_monitor_properties.sv
// ****************************************
// port-level checks of the event monitor
// ****************************************
module mpm_event_monitor_properties #(
  parameter int N_IN = 4
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic [N_IN-1:0] timer_event,
  input wire logic [N_IN-1:0] port_pin,
  input wire logic [7:0] addr,
  input wire logic [7:0] wdata,
  input wire logic wr,
  input wire logic rd,
  input wire logic [7:0] rdata,
  input wire logic [7:0] trig,
  input wire logic irq
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // write then read of input selector 6
  sequence s_wr_sel;
    wr && addr == 8'h00;
  endsequence
  sequence s_rd_sel;
    rd && addr == 8'h00;
  endsequence
  property p_sel_readback;
    s_wr_sel ##1 s_rd_sel |=> rdata == $past(wdata, 2);
  endproperty
  a_sel_readback: assert property (p_sel_readback) else $error("selector readback wrong");
  // read data stand only after a read
  property p_rd_idle;
    !rd |=> rdata == 8'h00;
  endproperty
  a_rd_idle: assert property (p_rd_idle) else $error("read data outside read slot");
  property p_unmapped;
    rd && addr > 8'h42 |=> rdata == 8'h00;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
  // only one destination at a time
  property p_one_dest;
    $onehot0(trig);
  endproperty
  a_one_dest: assert property (p_one_dest) else $error("several triggers at once");
  property p_trig_pulse;
    trig != 8'h00 |=> trig == 8'h00;
  endproperty
  a_trig_pulse: assert property (p_trig_pulse) else $error("trigger longer than a cycle");
  // no input change and no config change means no edge
  property p_quiet;
    $stable(timer_event) && $stable(port_pin) && !$past(wr) |=> trig == 8'h00;
  endproperty
  a_quiet: assert property (p_quiet) else $error("trigger without input edge");
  // irq only drops by a software write
  property p_irq_fall;
    $fell(irq) |-> $past(wr);
  endproperty
  a_irq_fall: assert property (p_irq_fall) else $error("irq dropped without write");
  property p_reset_quiet;
    $rose(rst_b) |-> (trig == 8'h00 && irq == 1'b0) [*2];
  endproperty
  a_reset_quiet: assert property (p_reset_quiet) else $error("output active after reset");
endmodule : mpm_event_monitor_properties

// ### mpm_event_source.sv
// ****************************************
// timer and pin event sources
// ****************************************
module mpm_event_source (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic go,
  input wire logic [3:0] te_set,
  input wire logic [3:0] pp_set,
  input wire logic [3:0] len,
  output logic [3:0] timer_event,
  output logic [3:0] port_pin
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [3:0] left_r; // cycles the levels still stand
  // a long len models a slow source; idle level is low
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      left_r <= 4'h0;
      timer_event <= 4'h0;
      port_pin <= 4'h0;
    end else if (go) begin
      left_r <= len;
      timer_event <= te_set;
      port_pin <= pp_set;
    end else if (left_r > 4'h1) begin
      left_r <= left_r - 4'h1;
    end else begin
      left_r <= 4'h0;
      timer_event <= 4'h0;
      port_pin <= 4'h0;
    end
  end
endmodule : mpm_event_source

// ### mpm_event_monitor_tb.sv
// ****************************************
// self-checking bench of the event monitor
// ****************************************
module mpm_event_monitor_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rst_b = 1'b0, wr = 1'b0, rd = 1'b0, go = 1'b0, irq;
  logic [3:0] te_set = 4'h0, pp_set = 4'h0, len = 4'h0, timer_event, port_pin;
  logic [3:0] vm = 4'hf, ps = 4'h0; // valid mask, pin select
  logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, trig, e, d;
  logic c1 = 1'b0, c2 = 1'b0, chk_en = 1'b0, neg_m = 1'b0;
  logic [2:0] dest_m = 3'h0;
  int bad_count = 0, samples_checked = 0, seen = 0, warm = 0, sd;
  // fixed fabric setup: link, cell, stage2/3, output
  localparam logic [15:0] TAB [28] = '{16'h0c01, 16'h0d02, 16'h0e03, 16'h0f04, 16'h100a,
    16'h1807, 16'h190d, 16'h1a0e, 16'h1c03, 16'h1e00, 16'h200a, 16'h2101, 16'h2202,
    16'h2401, 16'h2603, 16'h27c2, 16'h2808, 16'h2c04, 16'h2e00, 16'h300a, 16'h3401,
    16'h3603, 16'h37c0, 16'h3806, 16'h3b09, 16'h3c0e, 16'h3d0a, 16'h3e0f};

  mpm_event_monitor #(.N_IN(4)) u_dut (.clk(clk), .rst_b(rst_b), .timer_event(timer_event),
    .port_pin(port_pin), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata),
    .trig(trig), .irq(irq));
  mpm_event_source u_src (.clk(clk), .rst_b(rst_b), .go(go), .te_set(te_set),
    .pp_set(pp_set), .len(len), .timer_event(timer_event), .port_pin(port_pin));

  // ****************************************
  // helpers
  // ****************************************
  // or of the four sources after clamp and polarity
  function automatic logic comb_f(input logic [3:0] te, input logic [3:0] pp);
    return |((((ps & pp) | (~ps & te)) & vm) ^ {4{neg_m}});
  endfunction : comb_f
  task automatic chk(input logic [7:0] g, input logic [7:0] x);
    samples_checked++;
    if (g !== x) begin
      bad_count++;
      $display("MISMATCH %0t got %h want %h", $time, g, x);
    end
  endtask : chk
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] v);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= v;
    @(posedge clk);
    wr <= 1'b0;
  endtask : wr_reg
  // read data stand one cycle after the strobe
  task automatic rd_reg(input logic [7:0] a, output logic [7:0] v);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1 v = rdata;
  endtask : rd_reg
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] x);
    rd_reg(a, d);
    chk(d, x);
  endtask : rd_chk
  task automatic tab_chk(input logic z);
    for (int i = 0; i < 28; i++) rd_chk(TAB[i][15:8], z ? 8'h00 : TAB[i][7:0]);
  endtask : tab_chk
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
  endtask : idle
  task automatic cfg();
    for (int i = 0; i < 4; i++) begin
      wr_reg(8'(i), ps[i] ? 8'h01 : 8'h16);
      wr_reg(8'h08 + 8'(i), (neg_m ? 8'h17 : 8'h07) + 8'(i));
    end
    for (int i = 0; i < 28; i++) wr_reg(TAB[i][15:8], TAB[i][7:0]);
    wr_reg(8'h04, {4'h0, vm});
    wr_reg(8'h3f, {5'h0, dest_m});
  endtask : cfg
  task automatic conclude();
    $display("checks %0d mismatches %0d", samples_checked, bad_count);
    if (bad_count == 0 && samples_checked > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask : conclude

  // ****************************************
  // clock, trigger model, watchdog
  // ****************************************
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  // trig shows the rise of the or seen one edge earlier
  always @(negedge clk) begin
    if (chk_en && warm >= 2) begin
      e = (c1 && !c2) ? 8'h01 << dest_m : 8'h00;
      chk(trig, e);
      seen += int'(e != 8'h00);
    end
    warm = chk_en ? warm + 1 : 0;
    c2 = c1;
    c1 = comb_f(timer_event, port_pin);
  end
  initial begin
    repeat (60000) @(posedge clk);
    bad_count++;
    conclude();
  end

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    sd = $urandom(19303);
    idle(6);
    rst_b <= 1'b1;
    idle(4);
    tab_chk(1'b1);
    wr_reg(8'h50, 8'hff);
    rd_chk(8'h50, 8'h00);
    cfg();
    tab_chk(1'b0);
    // each source sets its own monitor bit and holds it
    wr_reg(8'h42, 8'h02);
    for (int n = 0; n < 4; n++) begin
      wr_reg(8'h40, 8'h0f);
      wr_reg(8'h41, 8'h03);
      @(posedge clk);
      go <= 1'b1;
      te_set <= 4'h1 << n;
      len <= 4'h1;
      @(posedge clk);
      go <= 1'b0;
      idle(4);
      rd_chk(8'h40, 8'h01 << n);
      chk({7'h0, irq}, 8'h01);
    end
    wr_reg(8'h42, 8'h00);
    rd_chk(8'h41, 8'h03);
    chk({7'h0, irq}, 8'h00);
    wr_reg(8'h41, 8'h03);
    rd_chk(8'h41, 8'h00);
    // random traffic, one destination and polarity per trial
    for (int t = 0; t < 8; t++) begin
      neg_m = t[0];
      vm = (t == 2) ? 4'h0 : 4'($urandom);
      ps = 4'($urandom);
      dest_m = 3'(t);
      cfg();
      wr_reg(8'h42, {7'h0, t == 0});
      idle(4);
      wr_reg(8'h41, 8'h03);
      seen = 0;
      chk_en = 1'b1;
      repeat (300) begin
        @(posedge clk);
        go <= ($urandom % 3 == 0);
        te_set <= 4'($urandom);
        pp_set <= 4'($urandom);
        len <= 4'(1 + $urandom % 4);
      end
      @(posedge clk);
      go <= 1'b0;
      idle(8);
      chk_en = 1'b0;
      if (t == 0) begin
        rd_reg(8'h41, d);
        chk(d & 8'h01, 8'(seen > 0));
        chk({7'h0, irq}, 8'(seen > 0));
      end
    end
    // second reset in mid-run
    rst_b <= 1'b0;
    idle(3);
    rst_b <= 1'b1;
    idle(4);
    rd_chk(8'h00, 8'h00);
    conclude();
  end
endmodule : mpm_event_monitor_tb

bind mpm_event_monitor mpm_event_monitor_properties #(.N_IN(N_IN)) u_props (.clk(clk),
  .rst_b(rst_b), .timer_event(timer_event), .port_pin(port_pin), .addr(addr),
  .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig(trig), .irq(irq));
